//--- hw/flash_host_pkg.sv
// Constants, types and helpers shared by the flash host controller files.
package flash_host_pkg;

	// ****************************************************************
	// Widths and timing
	// ****************************************************************
	localparam int AW          = 19;
	localparam int PW          = 18;
	localparam int DW          = 16;
	localparam int CLK_NS      = 20;
	localparam int STROBE_NS   = 100;
	localparam int SETTLE_NS   = 200;
	localparam int SYNC_CYC    = 2;
	localparam int STROBE_CYC  = (STROBE_NS + CLK_NS - 1) / CLK_NS;
	localparam int SETTLE_CYC  = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYC);
	localparam logic [3:0] READ_CNT   = 4'(STROBE_CYC + SYNC_CYC);
	localparam logic [3:0] SETTLE_CNT = 4'(SETTLE_CYC);

	// ****************************************************************
	// Command addresses, codes and pin fields
	// ****************************************************************
	localparam logic [AW-1:0] W_UNLOCK1 = 19'h0_0555;
	localparam logic [AW-1:0] W_UNLOCK2 = 19'h0_02AA;
	localparam logic [AW-1:0] B_UNLOCK1 = 19'h0_0AAA;
	localparam logic [AW-1:0] B_UNLOCK2 = 19'h0_0555;
	localparam logic [7:0] D_UNLOCK1     = 8'hAA;
	localparam logic [7:0] D_UNLOCK2     = 8'h55;
	localparam logic [7:0] D_ID          = 8'h90;
	localparam logic [7:0] D_PROG        = 8'hA0;
	localparam logic [7:0] D_ERASE_SETUP = 8'h80;
	localparam logic [7:0] D_CHIP        = 8'h10;
	localparam logic [7:0] D_SECTOR      = 8'h30;
	localparam logic [7:0] D_RESET       = 8'hF0;
	localparam int ID_SEL_BIT = 0;
	localparam int A9_BIT     = 9;
	localparam logic [DW-1:0] OE_NONE    = 16'h0000;
	localparam logic [DW-1:0] OE_WORD_WR = 16'hFFFF;
	localparam logic [DW-1:0] OE_BYTE_WR = 16'h80FF;
	localparam logic [DW-1:0] OE_BYTE_RD = 16'h8000;

	typedef enum logic [2:0] {
		CMD_RESET    = 3'h0,
		CMD_READ     = 3'h1,
		CMD_ID       = 3'h2,
		CMD_PROG     = 3'h3,
		CMD_CHIP_ER  = 3'h4,
		CMD_SECT_ER  = 3'h5,
		CMD_HV_ID    = 3'h6
	} cmd_t;

	typedef struct packed {
		logic          wr;
		logic [AW-1:0] addr;
		logic [DW-1:0] data;
		logic          last;
	} step_t;

	function automatic logic [DW-1:0] cmd_word(input logic [7:0] d);
		return {8'h00, d};
	endfunction

	function automatic logic [AW-1:0] unlock_addr(input logic second, input logic bm);
		if (bm) begin
			return second ? B_UNLOCK2 : B_UNLOCK1;
		end
		return second ? W_UNLOCK2 : W_UNLOCK1;
	endfunction

	// Byte addresses carry the low address pin in bit 0, so pin An sits one bit up.
	function automatic logic [AW-1:0] id_addr(input logic sel, input logic bm, input logic hv);
		logic [AW-1:0] a;
		a = '0;
		if (bm) begin
			a[ID_SEL_BIT + 1] = sel;
			a[A9_BIT + 1]     = hv;
		end else begin
			a[ID_SEL_BIT] = sel;
			a[A9_BIT]     = hv;
		end
		return a;
	endfunction

	function automatic logic is_long(input cmd_t c);
		return (c == CMD_PROG) || (c == CMD_CHIP_ER) || (c == CMD_SECT_ER);
	endfunction

endpackage

//--- hw/flash_bus_if.sv
// Link between the command sequencer and the pin cycle engine.
interface flash_bus_if;
	import flash_host_pkg::*;
	logic                req;
	logic                wr;
	logic                hv;
	logic                byte_mode;
	logic [AW-1:0]       addr;
	logic [DW-1:0]       wdata;
	logic                done;
	logic [DW-1:0]       rdata;
	modport seq (output req, wr, hv, byte_mode, addr, wdata, input done, rdata);
	modport eng (input req, wr, hv, byte_mode, addr, wdata, output done, rdata);
endinterface

//--- hw/flash_bus_cycle.sv
// Pin cycle engine: runs one read or write cycle on the flash pins.
module flash_bus_cycle
	import flash_host_pkg::*;
(
	input  wire logic          clk,
	input  wire logic          srst,
	flash_bus_if.eng           bus,
	input  wire logic [DW-1:0] dq_i,
	output logic               ce_n,
	output logic               oe_n,
	output logic               we_n,
	output logic               byte_n,
	output logic               a9_hv,
	output logic [PW-1:0]      addr,
	output logic [DW-1:0]      dq_o,
	output logic [DW-1:0]      dq_oe
);

	typedef enum logic [3:0] {
		E_IDLE   = 4'b0001,
		E_SETUP  = 4'b0010,
		E_STROBE = 4'b0100,
		E_HOLD   = 4'b1000
	} eng_st_t;

	eng_st_t       st_q, st_d;
	logic [3:0]    cnt_q, cnt_d;
	logic          ce_q, ce_d, oe_q, oe_d, we_q, we_d, byte_n_q, byte_n_d;
	logic          hv_q, hv_d, wr_q, wr_d, done_q, done_d;
	logic [PW-1:0] addr_q, addr_d;
	logic [DW-1:0] dqo_q, dqo_d, dqoe_q, dqoe_d, rdata_q, rdata_d;
	logic [DW-1:0] dq_m_q, dq_s_q;

	// ****************************************************************
	// Cycle sequencing
	// ****************************************************************
	always_comb begin
		st_d     = st_q;
		cnt_d    = cnt_q;
		ce_d     = ce_q;
		oe_d     = oe_q;
		we_d     = we_q;
		byte_n_d = byte_n_q;
		hv_d     = hv_q;
		wr_d     = wr_q;
		addr_d   = addr_q;
		dqo_d    = dqo_q;
		dqoe_d   = dqoe_q;
		rdata_d  = rdata_q;
		done_d   = 1'b0;
		case (st_q)
			E_IDLE: begin
				// A request still high in the done cycle is the old one.
				if (bus.req && !done_q) begin
					st_d     = E_SETUP;
					ce_d     = 1'b0;
					wr_d     = bus.wr;
					hv_d     = bus.hv;
					byte_n_d = !bus.byte_mode;
					if (bus.byte_mode) begin
						addr_d = bus.addr[AW-1:1];
						dqo_d  = {bus.addr[0], 7'h00, bus.wdata[7:0]};
						dqoe_d = bus.wr ? OE_BYTE_WR : OE_BYTE_RD;
					end else begin
						addr_d = bus.addr[PW-1:0];
						dqo_d  = bus.wdata;
						dqoe_d = bus.wr ? OE_WORD_WR : OE_NONE;
					end
				end
			end
			E_SETUP: begin
				st_d = E_STROBE;
				if (wr_q) begin
					we_d  = 1'b0;
					cnt_d = STROBE_CNT - 4'h1;
				end else begin
					oe_d  = 1'b0;
					cnt_d = READ_CNT - 4'h1;
				end
			end
			E_STROBE: begin
				if (cnt_q == 4'h0) begin
					st_d = E_HOLD;
					we_d = 1'b1;
					oe_d = 1'b1;
					if (!wr_q) begin
						// Only the low byte means anything in byte mode.
						rdata_d = byte_n_q ? dq_s_q : {8'h00, dq_s_q[7:0]};
					end
				end else begin
					cnt_d = cnt_q - 4'h1;
				end
			end
			E_HOLD: begin
				st_d   = E_IDLE;
				ce_d   = 1'b1;
				hv_d   = 1'b0;
				dqoe_d = OE_NONE;
				done_d = 1'b1;
			end
			default: begin
				st_d = E_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_q     <= E_IDLE;
			cnt_q    <= 4'h0;
			ce_q     <= 1'b1;
			oe_q     <= 1'b1;
			we_q     <= 1'b1;
			byte_n_q <= 1'b1;
			hv_q     <= 1'b0;
			wr_q     <= 1'b0;
			done_q   <= 1'b0;
			addr_q   <= '0;
			dqo_q    <= '0;
			dqoe_q   <= OE_NONE;
			rdata_q  <= '0;
			dq_m_q   <= '0;
			dq_s_q   <= '0;
		end else begin
			st_q     <= st_d;
			cnt_q    <= cnt_d;
			ce_q     <= ce_d;
			oe_q     <= oe_d;
			we_q     <= we_d;
			byte_n_q <= byte_n_d;
			hv_q     <= hv_d;
			wr_q     <= wr_d;
			done_q   <= done_d;
			addr_q   <= addr_d;
			dqo_q    <= dqo_d;
			dqoe_q   <= dqoe_d;
			rdata_q  <= rdata_d;
			dq_m_q   <= dq_i;
			dq_s_q   <= dq_m_q;
		end
	end

	assign bus.done  = done_q;
	assign bus.rdata = rdata_q;
	assign ce_n      = ce_q;
	assign oe_n      = oe_q;
	assign we_n      = we_q;
	assign byte_n    = byte_n_q;
	assign a9_hv     = hv_q;
	assign addr      = addr_q;
	assign dq_o      = dqo_q;
	assign dq_oe     = dqoe_q;

	// ****************************************************************
	// Checks
	// ****************************************************************
	strobe_excl_a: assert property (@(posedge clk) disable iff (srst) oe_q || we_q)
		else $error("write and output strobes both low");
	wr_strobe_a: assert property (@(posedge clk) disable iff (srst)
		$fell(we_q) |-> !ce_q && oe_q && (dqoe_q != OE_NONE))
		else $error("write strobe without select or data drive");
	rd_strobe_a: assert property (@(posedge clk) disable iff (srst)
		$fell(oe_q) |-> !ce_q && we_q && (dqoe_q[14:0] == 15'h0000))
		else $error("read strobe while driving data lines");
	wr_len_a: assert property (@(posedge clk) disable iff (srst)
		$fell(we_q) |-> (!we_q) [*5] ##1 we_q)
		else $error("write strobe width wrong");
	hv_id_a: assert property (@(posedge clk) disable iff (srst)
		hv_q |-> we_q && !addr_q[6] && !addr_q[1] && addr_q[A9_BIT])
		else $error("elevated id voltage with wrong address or write");

endmodule

//--- hw/flash_host_ctrl.sv
// Host-side controller that drives a parallel flash through its command sequences.
//
// Functional notes
// - Voltage identifier read: A9 elevated, A6 and A1 low, no command.
// - Identifier codes are also reached by the keyed command sequence.
// - One write of F0 to any address returns the device to array read.
// - Identifier: AA to 555, 55 to 2AA, 90 to 555, then reads.
// - Program: AA/555, 55/2AA, A0/555, then data to target address.
// - Chip erase: AA,55,80,AA,55 unlock writes, then 10 to 555.
// - Sector erase: same five writes, then 30 to the sector address.
// - Byte mode uses AAA and 555 on A10 to A-1.
// - Read: select low, output enable low, write strobe high, reset high.
// - Write: select low, output enable high, write strobe low, reset high.
module flash_host_ctrl
	import flash_host_pkg::*;
(
	input  wire logic          clk,
	input  wire logic          srst,
	input  wire logic          cmd_valid,
	input  wire cmd_t          cmd_code,
	input  wire logic [AW-1:0] cmd_addr,
	input  wire logic [DW-1:0] cmd_data,
	input  wire logic          byte_mode,
	output logic               cmd_ready,
	output logic               rsp_valid,
	output logic [DW-1:0]      rsp_data,
	output logic               fl_ce_n,
	output logic               fl_oe_n,
	output logic               fl_we_n,
	output logic               fl_reset_n,
	output logic               fl_byte_n,
	output logic               fl_a9_hv,
	output logic [PW-1:0]      fl_addr,
	output logic [DW-1:0]      fl_dq_o,
	output logic [DW-1:0]      fl_dq_oe,
	input  wire logic [DW-1:0] fl_dq_i,
	input  wire logic          fl_ready_i
);

	typedef enum logic [4:0] {
		S_IDLE   = 5'b00001,
		S_CYCLE  = 5'b00010,
		S_SETTLE = 5'b00100,
		S_BUSY   = 5'b01000,
		S_RESP   = 5'b10000
	} seq_st_t;

	seq_st_t       st_q, st_d;
	cmd_t          cmd_q, cmd_d;
	logic [AW-1:0] addr_q, addr_d;
	logic [DW-1:0] data_q, data_d, rsp_data_q, rsp_data_d;
	logic [2:0]    step_q, step_d;
	logic [3:0]    cnt_q, cnt_d;
	logic          byte_q, byte_d, req_q, req_d;
	logic          ready_q, ready_d, rsp_valid_q, rsp_valid_d;
	logic          rst_pin_q, rdy_m_q, rdy_s_q;
	step_t         step;

	flash_bus_if bus ();

	// ****************************************************************
	// Command sequence table
	// ****************************************************************
	// Every keyed sequence starts from its first unlock write, so the host never
	// leaves the device part way through a key it could misread.
	function automatic step_t seq_step(input cmd_t c, input logic [2:0] i, input logic bm,
		input logic [AW-1:0] ua, input logic [DW-1:0] ud);
		step_t         s;
		logic [AW-1:0] u1;
		logic [AW-1:0] u2;
		u1     = unlock_addr(1'b0, bm);
		u2     = unlock_addr(1'b1, bm);
		s.wr   = 1'b1;
		s.addr = u1;
		s.data = cmd_word(D_UNLOCK1);
		s.last = 1'b0;
		case (c)
			CMD_RESET: begin
				s.addr = ua;
				s.data = cmd_word(D_RESET);
				s.last = 1'b1;
			end
			CMD_READ: begin
				s.wr   = 1'b0;
				s.addr = ua;
				s.last = 1'b1;
			end
			CMD_HV_ID: begin
				s.wr   = 1'b0;
				s.addr = id_addr(ua[0], bm, 1'b1);
				s.last = 1'b1;
			end
			default: begin
				case (i)
					3'h0: s.data = cmd_word(D_UNLOCK1);
					3'h1: begin
						s.addr = u2;
						s.data = cmd_word(D_UNLOCK2);
					end
					3'h2: begin
						if (c == CMD_ID) begin
							s.data = cmd_word(D_ID);
						end else if (c == CMD_PROG) begin
							s.data = cmd_word(D_PROG);
						end else begin
							s.data = cmd_word(D_ERASE_SETUP);
						end
					end
					3'h3: begin
						if (c == CMD_ID) begin
							s.wr   = 1'b0;
							s.addr = id_addr(ua[0], bm, 1'b0);
							s.last = 1'b1;
						end else if (c == CMD_PROG) begin
							s.addr = ua;
							s.data = bm ? cmd_word(ud[7:0]) : ud;
							s.last = 1'b1;
						end
					end
					3'h4: begin
						s.addr = u2;
						s.data = cmd_word(D_UNLOCK2);
					end
					default: begin
						s.last = 1'b1;
						if (c == CMD_SECT_ER) begin
							s.addr = ua;
							s.data = cmd_word(D_SECTOR);
						end else begin
							s.data = cmd_word(D_CHIP);
						end
					end
				endcase
			end
		endcase
		return s;
	endfunction

	// The table is the only source of bus traffic, which keeps every write on
	// a valid sequence and avoids an accidental abort.
	assign step          = seq_step(cmd_q, step_q, byte_q, addr_q, data_q);
	assign bus.req       = req_q;
	assign bus.wr        = step.wr;
	assign bus.hv        = (cmd_q == CMD_HV_ID);
	assign bus.byte_mode = byte_q;
	assign bus.addr      = step.addr;
	assign bus.wdata     = step.data;

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	always_comb begin
		st_d        = st_q;
		cmd_d       = cmd_q;
		addr_d      = addr_q;
		data_d      = data_q;
		byte_d      = byte_q;
		step_d      = step_q;
		cnt_d       = cnt_q;
		req_d       = req_q;
		ready_d     = ready_q;
		rsp_data_d  = rsp_data_q;
		rsp_valid_d = 1'b0;
		case (st_q)
			S_IDLE: begin
				ready_d = 1'b1;
				if (cmd_valid && ready_q) begin
					st_d    = S_CYCLE;
					cmd_d   = cmd_code;
					addr_d  = cmd_addr;
					data_d  = cmd_data;
					byte_d  = byte_mode;
					step_d  = 3'h0;
					req_d   = 1'b1;
					ready_d = 1'b0;
				end
			end
			S_CYCLE: begin
				if (bus.done) begin
					if (step.last) begin
						req_d = 1'b0;
						if (!step.wr) begin
							rsp_data_d = bus.rdata;
						end
						if (is_long(cmd_q)) begin
							st_d  = S_SETTLE;
							cnt_d = SETTLE_CNT;
						end else begin
							st_d = S_RESP;
						end
					end else begin
						step_d = step_q + 3'h1;
					end
				end
			end
			S_SETTLE: begin
				// The busy flag lags the last write, so it is not trusted at once.
				if (cnt_q == 4'h0) begin
					st_d = S_BUSY;
				end else begin
					cnt_d = cnt_q - 4'h1;
				end
			end
			S_BUSY: begin
				if (rdy_s_q) begin
					st_d = S_RESP;
				end
			end
			S_RESP: begin
				rsp_valid_d = 1'b1;
				ready_d     = 1'b1;
				st_d        = S_IDLE;
			end
			default: begin
				st_d = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_q        <= S_IDLE;
			cmd_q       <= CMD_READ;
			addr_q      <= '0;
			data_q      <= '0;
			byte_q      <= 1'b0;
			step_q      <= 3'h0;
			cnt_q       <= 4'h0;
			req_q       <= 1'b0;
			ready_q     <= 1'b0;
			rsp_data_q  <= '0;
			rsp_valid_q <= 1'b0;
			rst_pin_q   <= 1'b0;
			rdy_m_q     <= 1'b0;
			rdy_s_q     <= 1'b0;
		end else begin
			st_q        <= st_d;
			cmd_q       <= cmd_d;
			addr_q      <= addr_d;
			data_q      <= data_d;
			byte_q      <= byte_d;
			step_q      <= step_d;
			cnt_q       <= cnt_d;
			req_q       <= req_d;
			ready_q     <= ready_d;
			rsp_data_q  <= rsp_data_d;
			rsp_valid_q <= rsp_valid_d;
			rst_pin_q   <= 1'b1;
			rdy_m_q     <= fl_ready_i;
			rdy_s_q     <= rdy_m_q;
		end
	end

	flash_bus_cycle u_cycle (
		.clk    (clk),
		.srst   (srst),
		.bus    (bus.eng),
		.dq_i   (fl_dq_i),
		.ce_n   (fl_ce_n),
		.oe_n   (fl_oe_n),
		.we_n   (fl_we_n),
		.byte_n (fl_byte_n),
		.a9_hv  (fl_a9_hv),
		.addr   (fl_addr),
		.dq_o   (fl_dq_o),
		.dq_oe  (fl_dq_oe)
	);

	assign cmd_ready  = ready_q;
	assign rsp_valid  = rsp_valid_q;
	assign rsp_data   = rsp_data_q;
	assign fl_reset_n = rst_pin_q;

	// ****************************************************************
	// Checks
	// ****************************************************************
	reset_pin_a: assert property (@(posedge clk) disable iff (srst)
		cmd_ready |-> fl_reset_n)
		else $error("ready while flash reset pin low");
	reset_cmd_a: assert property (@(posedge clk) disable iff (srst)
		(req_q && cmd_q == CMD_RESET) |-> step.wr && step.last && step.data[7:0] == D_RESET)
		else $error("reset command not a single F0 write");
	unlock_first_a: assert property (@(posedge clk) disable iff (srst)
		(req_q && step_q == 3'h0 && cmd_q != CMD_RESET && cmd_q != CMD_READ
		&& cmd_q != CMD_HV_ID) |-> step.wr && step.data[7:0] == D_UNLOCK1
		&& step.addr == unlock_addr(1'b0, byte_q))
		else $error("keyed sequence does not open with first unlock");
	chip_last_a: assert property (@(posedge clk) disable iff (srst)
		(req_q && cmd_q == CMD_CHIP_ER && step.last) |-> step_q == 3'h5
		&& step.data[7:0] == D_CHIP && step.addr == unlock_addr(1'b0, byte_q))
		else $error("chip erase final write wrong");
	sect_last_a: assert property (@(posedge clk) disable iff (srst)
		(req_q && cmd_q == CMD_SECT_ER && step.last) |-> step_q == 3'h5
		&& step.data[7:0] == D_SECTOR && step.addr == addr_q)
		else $error("sector erase final write wrong");
	busy_wait_a: assert property (@(posedge clk) disable iff (srst)
		(rsp_valid_q && is_long(cmd_q)) |-> $past(rdy_s_q, 2))
		else $error("long operation answered before device ready");

endmodule

//--- dv/flash_dev_model.sv
// Behavioural parallel flash device answering the host controller's pin cycles.
module flash_dev_model
	import flash_host_pkg::*;
#(
	parameter logic [7:0]  MAKER_CODE = 8'h5A,   // Arbitrary value.
	parameter logic [15:0] DEV_TOP    = 16'h3C71, // Arbitrary value.
	parameter logic [15:0] DEV_BOT    = 16'h3C72, // Arbitrary value.
	parameter bit          BOOT_TOP   = 1'b1,
	parameter int          BUSY_NS    = 2000
)(
	input  wire logic          ce_n,
	input  wire logic          oe_n,
	input  wire logic          we_n,
	input  wire logic          reset_n,
	input  wire logic          byte_n,
	input  wire logic          a9_hv,
	input  wire logic [PW-1:0] addr,
	input  wire logic [DW-1:0] dq,
	output logic [DW-1:0]      q,
	output logic [DW-1:0]      q_oe,
	output logic               ready
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************************************
	// Command decoder and array
	// ****************************************************************
	logic [15:0] mem [int];
	logic [15:0] old;
	logic [15:0] rv;
	logic [15:0] dev_code;
	logic [11:0] ca;
	logic [11:0] u1;
	logic [11:0] u2;
	logic [7:0]  d;
	logic        id_q = 1'b0;
	logic        busy = 1'b0;
	int          st = 0;
	int          upd = 0;

	assign dev_code = BOOT_TOP ? DEV_TOP : DEV_BOT;
	assign ca = byte_n ? {1'b0, addr[10:0]} : {addr[10:0], dq[15]};
	assign u1 = byte_n ? 12'h555 : 12'hAAA;
	assign u2 = byte_n ? 12'h2AA : 12'h555;
	assign ready = ~busy;

	// A reset ends any busy period at once, so the host never waits on stale work.
	always @(negedge reset_n) begin
		st = 0;
		id_q = 1'b0;
		busy = 1'b0;
	end

	always @(posedge busy) begin
		#(BUSY_NS);
		busy = 1'b0;
	end

	always @(posedge we_n) begin
		if (ce_n === 1'b0 && oe_n === 1'b1 && reset_n === 1'b1 && !busy) begin
			d = dq[7:0];
			id_q = 1'b0;
			old = mem.exists(int'(addr)) ? mem[int'(addr)] : 16'hFFFF;
			if (d == 8'hF0) begin
				st = 0;
			end else begin
				case (st)
					0: st = (d == 8'hAA && ca == u1) ? 1 : 0;
					1: st = (d == 8'h55 && ca == u2) ? 2 : 0;
					2: begin
						st = 0;
						if (ca == u1 && d == 8'h90) id_q = 1'b1;
						if (ca == u1 && d == 8'hA0) st = 3;
						if (ca == u1 && d == 8'h80) st = 4;
					end
					3: begin
						if (byte_n) mem[int'(addr)] = old & dq;
						else if (dq[15]) mem[int'(addr)] = old & {d, 8'hFF};
						else mem[int'(addr)] = old & {8'hFF, d};
						st = 0;
						busy = 1'b1;
					end
					4: st = (d == 8'hAA && ca == u1) ? 5 : 0;
					5: st = (d == 8'h55 && ca == u2) ? 6 : 0;
					6: begin
						if (ca == u1 && d == 8'h10) begin
							mem.delete();
							busy = 1'b1;
						end
						if (d == 8'h30) begin
							foreach (mem[k]) if (k[17:12] == addr[17:12]) mem[k] = 16'hFFFF;
							busy = 1'b1;
						end
						st = 0;
					end
					default: st = 0;
				endcase
			end
			upd++;
		end
	end

	always @(ce_n or oe_n or we_n or reset_n or byte_n or a9_hv or addr or dq or id_q or upd) begin
		rv = mem.exists(int'(addr)) ? mem[int'(addr)] : 16'hFFFF;
		if (!byte_n) rv = {8'h00, dq[15] ? rv[15:8] : rv[7:0]};
		if (!addr[1] && (id_q || (a9_hv && addr[9] && !addr[6]))) begin
			rv = addr[0] ? dev_code : {8'h00, MAKER_CODE};
		end
		q = rv;
		q_oe = 16'h0000;
		if (!ce_n && !oe_n && we_n && reset_n) q_oe = byte_n ? 16'hFFFF : 16'h00FF;
	end
endmodule

//--- dv/tb_flash_host_ctrl.sv
// Self-checking bench for the flash host controller against a behavioural device.
module tb_flash_host_ctrl
	import flash_host_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************************************
	// Harness
	// ****************************************************************
	logic clk = 1'b0, srst = 1'b1, cmd_valid = 1'b0, byte_mode = 1'b0;
	cmd_t cmd_code = CMD_READ;
	logic [AW-1:0] cmd_addr = '0;
	logic [DW-1:0] cmd_data = '0, pat = 16'hA5C3, rsp_data, fl_dq_o, fl_dq_oe, dev_q, dev_oe, r;
	logic cmd_ready, rsp_valid, fl_ce_n, fl_oe_n, fl_we_n, fl_reset_n, fl_byte_n, fl_a9_hv, rdy;
	logic [PW-1:0] fl_addr;
	wire logic [DW-1:0] fl_dq_i;
	int failures = 0, tests_run = 0, cyc;
	localparam logic [15:0] MK = 16'h005A, DV = 16'h3C71;

	initial forever #10 clk = ~clk;
	// Undriven data lines toggle every cycle so a stale value never passes for data.
	always @(posedge clk) pat <= ~pat;
	assign fl_dq_i = (fl_dq_oe & fl_dq_o) | (~fl_dq_oe & dev_oe & dev_q) | (~fl_dq_oe & ~dev_oe & pat);

	flash_host_ctrl dut (.clk(clk), .srst(srst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
		.cmd_addr(cmd_addr), .cmd_data(cmd_data), .byte_mode(byte_mode), .cmd_ready(cmd_ready),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
		.fl_we_n(fl_we_n), .fl_reset_n(fl_reset_n), .fl_byte_n(fl_byte_n), .fl_a9_hv(fl_a9_hv),
		.fl_addr(fl_addr), .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe), .fl_dq_i(fl_dq_i),
		.fl_ready_i(rdy));
	flash_dev_model dev (.ce_n(fl_ce_n), .oe_n(fl_oe_n), .we_n(fl_we_n), .reset_n(fl_reset_n),
		.byte_n(fl_byte_n), .a9_hv(fl_a9_hv), .addr(fl_addr), .dq(fl_dq_i), .q(dev_q),
		.q_oe(dev_oe), .ready(rdy));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic issue(input cmd_t c, input logic [AW-1:0] a, input logic [DW-1:0] dd,
			input logic bm);
		int i;
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_code <= c;
		cmd_addr <= a;
		cmd_data <= dd;
		byte_mode <= bm;
		i = 0;
		do begin @(negedge clk); i++; end while (cmd_ready !== 1'b1 && i < 100);
		@(posedge clk);
		cmd_valid <= 1'b0;
		if (i >= 100) begin failures++; finish_test(); end
	endtask

	task automatic do_cmd(input cmd_t c, input logic [AW-1:0] a, input logic [DW-1:0] dd,
			input logic bm);
		issue(c, a, dd, bm);
		cyc = 0;
		do begin @(negedge clk); cyc++; end while (rsp_valid !== 1'b1 && cyc < 5000);
		if (cyc >= 5000) begin failures++; finish_test(); end
		r = rsp_data;
	endtask

	// Pin cycle shape is watched throughout the run.
	always @(negedge clk) begin
		if (fl_ce_n === 1'b0) begin
			check({fl_oe_n, fl_we_n} == 2'b00, 1'b0);
			if (fl_oe_n === 1'b0 && fl_byte_n === 1'b0) check(fl_dq_oe, 16'h8000);
		end
	end

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_boot_read();
		// The pin and ready rise at the first edge after release, so look once it has passed.
		@(posedge clk);
		@(negedge clk);
		check({fl_reset_n, cmd_ready}, 2'b11);
		do_cmd(CMD_READ, 19'h0_0040, '0, 1'b0);
		check(r, 16'hFFFF);
	endtask

	task automatic t_keyed_id();
		for (int bm = 0; bm < 2; bm++) begin
			for (int s = 0; s < 2; s++) begin
				do_cmd(CMD_ID, 19'(s), '0, 1'(bm));
				check(r, s == 0 ? MK : (bm == 1 ? {8'h00, DV[7:0]} : DV));
			end
		end
		do_cmd(CMD_RESET, 19'h1_2345, '0, 1'b0);
		do_cmd(CMD_READ, 19'h0_0001, '0, 1'b0);
		check(r, 16'hFFFF);
	endtask

	task automatic t_hv_id();
		for (int s = 0; s < 2; s++) begin
			do_cmd(CMD_HV_ID, 19'(s), '0, 1'b0);
			check(r, s == 0 ? MK : DV);
		end
	endtask

	task automatic t_prog_erase();
		do_cmd(CMD_PROG, 19'h0_F123, 16'h1234, 1'b0);
		check(cyc >= 100, 1'b1);
		do_cmd(CMD_PROG, 19'h0_1123, 16'h00FF, 1'b0);
		do_cmd(CMD_READ, 19'h0_F123, '0, 1'b0);
		check(r, 16'h1234);
		do_cmd(CMD_SECT_ER, 19'h0_F000, '0, 1'b0);
		do_cmd(CMD_READ, 19'h0_F123, '0, 1'b0);
		check(r, 16'hFFFF);
		do_cmd(CMD_READ, 19'h0_1123, '0, 1'b0);
		check(r, 16'h00FF);
		do_cmd(CMD_CHIP_ER, 19'h0_0000, '0, 1'b0);
		do_cmd(CMD_READ, 19'h0_1123, '0, 1'b0);
		check(r, 16'hFFFF);
		do_cmd(CMD_PROG, 19'h0_2247, 16'h000F, 1'b1);
		do_cmd(CMD_READ, 19'h0_1123, '0, 1'b0);
		check(r, 16'h0FFF);
		do_cmd(CMD_READ, 19'h0_2247, '0, 1'b1);
		check(r, 16'h000F);
	endtask

	task automatic t_reset_busy();
		issue(CMD_PROG, 19'h0_3001, 16'hBEEF, 1'b0);
		repeat (60) @(posedge clk);
		srst <= 1'b1;
		repeat (3) @(posedge clk);
		@(negedge clk);
		check({fl_reset_n, fl_ce_n, fl_dq_oe}, {2'b01, 16'h0000});
		check({cmd_ready, rsp_valid, fl_oe_n, fl_we_n, fl_a9_hv}, 5'b00110);
		@(posedge clk);
		srst <= 1'b0;
		do_cmd(CMD_READ, 19'h0_3001, '0, 1'b0);
		check(r, 16'hBEEF);
	endtask

	initial begin
		repeat (9) @(posedge clk);
		@(negedge clk);
		check({fl_reset_n, fl_ce_n, fl_oe_n, fl_we_n, cmd_ready}, 5'b01110);
		@(posedge clk);
		srst <= 1'b0;
		t_boot_read();
		t_keyed_id();
		t_hv_id();
		t_prog_erase();
		t_reset_busy();
		finish_test();
	end
endmodule
